// ===== design/modem_packet_ram_access_regs.sv
// Modem serial register front end with packet RAM ports and stream FIFO
`timescale 1ns/1ps

// Single-clock FIFO with valid/ready on both sides
module stream_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Handshakes and honest full/empty
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : stream_fifo

// Register front end: serial link domain plus core domain
module modem_packet_ram_access_regs #(
  parameter int RAM_WORDS = modem_regs_pkg::RAM_DEPTH,
  parameter int FIFO_WORDS = modem_regs_pkg::FIFO_DEPTH,
  parameter logic [3:0] PART_ID = modem_regs_pkg::PART_ID_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spi_clk,
  input wire logic ce_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic irq_n,
  output logic soft_reset_active,
  input wire logic [15:0] irq_mask,
  input wire logic rx_stream_en,
  input wire logic tx_stream_en,
  input wire logic rx_pkt_wr,
  input wire modem_regs_pkg::rx_word_t rx_pkt_in,
  input wire logic rx_pkt_done,
  input wire logic [6:0] rx_pkt_len,
  input wire logic [7:0] cca_final,
  input wire logic rx_strm_valid,
  input wire logic [15:0] rx_strm_data,
  output logic rx_strm_ready,
  input wire logic [5:0] tx_rd_idx,
  output logic [15:0] tx_rd_data,
  output logic [6:0] tx_len,
  output logic tx_sel,
  input wire logic tx_need,
  input wire logic tx_sent,
  output logic [15:0] tx_strm_word,
  output logic tx_strm_valid,
  input wire logic [23:0] event_time,
  input wire logic [23:0] frame_stamp,
  input wire logic [6:0] gpio_in,
  output logic ber_en
);
  import modem_regs_pkg::*;

  // ---------------- Serial link domain ----------------
  logic spi_arst;
  logic [3:0] cnt_r;
  logic data_ph_r;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic rw_r;
  logic srst_r;
  logic [15:0] out_sh_r;
  logic miso_oe_r;
  spi_access_t acc_r;
  logic wr_tgl_r;
  logic rd_tgl_r;
  logic [15:0] rd_hold_r;

  // Link logic idles whenever chip enable is high
  assign spi_arst = rst | ce_n;
  assign sh_nxt = {sh_r[14:0], mosi};
  assign miso = out_sh_r[15];
  assign miso_oe = miso_oe_r;

  // Frame sequencing, shifting and soft reset request
  always_ff @(posedge spi_clk or posedge spi_arst) begin
    if (spi_arst) begin
      cnt_r <= 4'h0;
      data_ph_r <= 1'b0;
      sh_r <= 16'h0000;
      rw_r <= 1'b0;
      srst_r <= 1'b0;
      out_sh_r <= 16'h0000;
      miso_oe_r <= 1'b0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_r + 4'h1;
      if (!data_ph_r && cnt_r == HDR_ADDR_DONE) begin
        rw_r <= sh_nxt[HDR_RW_BIT];
        if (!sh_nxt[HDR_RW_BIT] && sh_nxt[5:0] == ADDR_SOFT_RESET) begin
          srst_r <= 1'b1;
        end
      end
      if (cnt_r == WORD_DONE) begin
        data_ph_r <= 1'b1;
        out_sh_r <= rd_hold_r; // Quasi-static word from core
        miso_oe_r <= rw_r;
      end else begin
        out_sh_r <= {out_sh_r[14:0], 1'b0};
      end
    end
  end

  // Access toggles survive frame ends so the core sees each edge once
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      wr_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
    end else begin
      if (!data_ph_r && cnt_r == HDR_ADDR_DONE) begin
        acc_r.addr <= sh_nxt[5:0];
      end
      if (cnt_r == WORD_DONE && rw_r) begin
        rd_tgl_r <= ~rd_tgl_r;
      end
      if (data_ph_r && cnt_r == WORD_DONE && !rw_r) begin
        acc_r.data <= sh_nxt;
        wr_tgl_r <= ~wr_tgl_r;
      end
    end
  end

  // ---------------- Core domain ----------------
  logic [SYNC_W-1:0] sync_a_r;
  logic [SYNC_W-1:0] sync_b_r;
  logic wr_prev_r;
  logic rd_prev_r;
  logic wr_ev;
  logic rd_ev;
  logic frame_idle;
  logic soft_rst;
  logic [6:0] pins;
  logic [SYNC_W-1:0] sync_in;

  assign sync_in = {gpio_in, rd_tgl_r, wr_tgl_r, srst_r, ce_n};

  // Two-stage synchronisers for link and pin levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_a_r <= SYNC_RST;
      sync_b_r <= SYNC_RST;
    end else begin
      sync_a_r <= sync_in;
      sync_b_r <= sync_a_r;
    end
  end

  // Toggle edge detection on the second stage only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
    end else begin
      wr_prev_r <= sync_b_r[SYNC_WR];
      rd_prev_r <= sync_b_r[SYNC_RD];
    end
  end

  assign wr_ev = sync_b_r[SYNC_WR] ^ wr_prev_r;
  assign rd_ev = sync_b_r[SYNC_RD] ^ rd_prev_r;
  assign frame_idle = sync_b_r[SYNC_CE];
  assign soft_rst = sync_b_r[SYNC_SRST];
  assign pins = sync_b_r[SYNC_W-1:SYNC_PIN_LO];
  assign soft_reset_active = soft_rst;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
    hit = (a == r);
  endfunction : hit

  logic wr_tx_port;
  logic wr_tx_ctl;
  logic wr_ber;
  logic rd_rx_port;
  logic rd_tx_port;
  logic rd_flags;
  logic rd_cause;

  // Side effects happen only at decoded events
  assign wr_tx_port = wr_ev & hit(acc_r.addr, ADDR_TX_PORT);
  assign wr_tx_ctl = wr_ev & hit(acc_r.addr, ADDR_TX_CTL);
  assign wr_ber = wr_ev & hit(acc_r.addr, ADDR_BER_EN);
  assign rd_rx_port = rd_ev & hit(acc_r.addr, ADDR_RX_PORT);
  assign rd_tx_port = rd_ev & hit(acc_r.addr, ADDR_TX_PORT);
  assign rd_flags = rd_ev & hit(acc_r.addr, ADDR_FLAGS);
  assign rd_cause = rd_ev & hit(acc_r.addr, ADDR_RESET_CAUSE);

  // Packet RAMs: never reset, so soft reset keeps their contents
  logic [15:0] rx_ram [0:RAM_WORDS-1];
  logic [15:0] tx_ram [0:1][0:RAM_WORDS-1];
  logic [IDX_W-1:0] rx_ptr_r;
  logic [IDX_W-1:0] tx_ptr_r;

  always_ff @(posedge core_clk) begin
    if (rx_pkt_wr) begin
      rx_ram[rx_pkt_in.idx] <= rx_pkt_in.data;
    end
    if (wr_tx_port && !tx_stream_en) begin
      tx_ram[tx_sel][tx_ptr_r] <= acc_r.data;
    end
  end

  // Burst pointers restart at every frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_ptr_r <= '0;
      tx_ptr_r <= '0;
    end else if (frame_idle || soft_rst) begin
      rx_ptr_r <= '0;
      tx_ptr_r <= '0;
    end else begin
      if (rd_rx_port && !rx_stream_en) begin
        rx_ptr_r <= rx_ptr_r + 1'b1;
      end
      if (wr_tx_port || rd_tx_port) begin
        tx_ptr_r <= tx_ptr_r + 1'b1;
      end
    end
  end

  // Transmit control and test enable registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_sel <= TX_SEL_RST;
      tx_len <= TX_LEN_RST;
      ber_en <= BER_EN_RST;
    end else if (soft_rst) begin
      tx_sel <= TX_SEL_RST;
      tx_len <= TX_LEN_RST;
      ber_en <= BER_EN_RST;
    end else begin
      if (wr_tx_ctl) begin
        tx_sel <= acc_r.data[TX_SEL_BIT];
        tx_len <= acc_r.data[LEN_W-1:0];
      end
      if (wr_ber) begin
        ber_en <= acc_r.data[BER_EN_BIT];
      end
    end
  end

  // Transmit data toward the radio
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_rd_data <= 16'h0000;
      tx_strm_word <= 16'h0000;
      tx_strm_valid <= 1'b0;
    end else begin
      tx_rd_data <= tx_ram[tx_sel][tx_rd_idx];
      tx_strm_valid <= wr_tx_port & tx_stream_en;
      if (wr_tx_port && tx_stream_en) begin
        tx_strm_word <= acc_r.data;
      end
    end
  end

  // Stream receive buffering
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic fifo_pop;
  logic [15:0] rx_port_r;
  logic port_full_r;

  assign fifo_pop = fifo_valid & rx_stream_en & ~port_full_r;

  stream_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_WORDS)
  ) u_rx_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_valid(rx_strm_valid),
    .in_data(rx_strm_data),
    .in_ready(rx_strm_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // Receive port holds one stream word until the host reads it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_port_r <= 16'h0000;
      port_full_r <= 1'b0;
    end else if (soft_rst) begin
      port_full_r <= 1'b0;
    end else if (fifo_pop) begin
      rx_port_r <= fifo_data;
      port_full_r <= 1'b1;
    end else if (rd_rx_port) begin
      port_full_r <= 1'b0;
    end
  end

  // Sticky event flags; a set in the clearing cycle wins
  logic rx_strm_f_r;
  logic tx_strm_f_r;
  logic rcvd_f_r;
  logic sent_f_r;
  logic [6:0] rx_len_r;
  logic reset_cause_r;
  logic [15:0] flags;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_strm_f_r <= 1'b0;
      tx_strm_f_r <= 1'b0;
      rcvd_f_r <= 1'b0;
      sent_f_r <= 1'b0;
    end else if (soft_rst) begin
      rx_strm_f_r <= 1'b0;
      tx_strm_f_r <= 1'b0;
      rcvd_f_r <= 1'b0;
      sent_f_r <= 1'b0;
    end else begin
      rx_strm_f_r <= fifo_pop | (rx_strm_f_r & ~rd_rx_port & ~rd_flags);
      tx_strm_f_r <= (tx_need & tx_stream_en)
        | (tx_strm_f_r & ~wr_tx_port & ~rd_flags);
      rcvd_f_r <= rx_pkt_done | (rcvd_f_r & ~rd_flags);
      sent_f_r <= tx_sent | (sent_f_r & ~rd_flags);
    end
  end

  assign flags = FLAGS_RST
    | (16'(rx_strm_f_r | tx_strm_f_r) << FLAG_STREAM_BIT)
    | (16'(rcvd_f_r) << FLAG_RX_RCVD_BIT)
    | (16'(sent_f_r) << FLAG_TX_SENT_BIT);

  // Receive length, reset cause and interrupt pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_len_r <= 7'h00;
      reset_cause_r <= 1'b1;
      irq_n <= 1'b1;
    end else begin
      if (soft_rst) begin
        rx_len_r <= 7'h00;
      end else if (rx_pkt_done) begin
        rx_len_r <= rx_pkt_len;
      end
      reset_cause_r <= soft_rst | (reset_cause_r & ~rd_cause);
      irq_n <= ~|(flags & irq_mask);
    end
  end

  // Read data kept current for the link to sample
  logic [15:0] rd_mux;

  always_comb begin
    rd_mux = 16'h0000; // Unmapped, reserved and address 00 read zero
    case (acc_r.addr)
      ADDR_RX_PORT: rd_mux = rx_stream_en ? rx_port_r : rx_ram[rx_ptr_r];
      ADDR_TX_PORT: rd_mux = tx_ram[tx_sel][tx_ptr_r];
      ADDR_TX_CTL: rd_mux = {tx_sel, 8'h00, tx_len};
      ADDR_FLAGS: rd_mux = flags;
      ADDR_RESET_CAUSE: rd_mux = {8'h00, reset_cause_r, 7'h00};
      ADDR_TIME_HI: rd_mux = {8'h00, event_time[23:16]};
      ADDR_TIME_LO: rd_mux = event_time[15:0];
      ADDR_PIN_IN: rd_mux = {1'b0, pins, 8'h00};
      ADDR_PART_ID: rd_mux = {4'h0, PART_ID, 8'h00};
      ADDR_RX_QUAL: rd_mux = {cca_final, 1'b0, rx_len_r};
      ADDR_STAMP_HI: rd_mux = {8'h00, frame_stamp[23:16]};
      ADDR_STAMP_LO: rd_mux = frame_stamp[15:0];
      ADDR_BER_EN: rd_mux = {ber_en, 15'h0000};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_hold_r <= 16'h0000;
    end else begin
      rd_hold_r <= rd_mux;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_sel_write: assert property (wr_tx_ctl |=> tx_sel == $past(acc_r.data[15]))
    else $error("transmit RAM choice did not follow write");
  a_len_write: assert property (wr_tx_ctl |=> tx_len == $past(acc_r.data[6:0]))
    else $error("transmit length did not follow write");
  a_rx_strm_clear: assert property (rd_rx_port && !fifo_pop && !soft_rst |=> !rx_strm_f_r)
    else $error("receive port read left stream flag set");
  a_tx_strm_clear: assert property (wr_tx_port && !tx_need && !soft_rst |=> !tx_strm_f_r)
    else $error("transmit port write left stream flag set");
  a_rx_strm_set: assert property (fifo_pop && !soft_rst |=> rx_strm_f_r && port_full_r)
    else $error("stream word did not raise status");
  a_tx_need_set: assert property (tx_need && tx_stream_en && !soft_rst |=> tx_strm_f_r)
    else $error("transmit need did not raise status");
  a_irq_pin: assert property (|(flags & irq_mask) |=> !irq_n)
    else $error("enabled status did not drive interrupt");
  a_irq_quiet: assert property (!(|(flags & irq_mask)) |=> irq_n)
    else $error("interrupt without enabled status");
  a_soft_defaults: assert property (soft_rst |=> tx_len == TX_LEN_RST && !tx_sel && flags == 16'h0000)
    else $error("soft reset did not restore defaults");
  a_rx_len_latch: assert property (rx_pkt_done && !soft_rst |=> rx_len_r == $past(rx_pkt_len))
    else $error("receive length not latched");
  // A stream word may still load the port in the cycle of a stray write
  a_rx_port_ro: assert property (
    wr_ev && hit(acc_r.addr, ADDR_RX_PORT) && !fifo_pop
    |=> $stable(rx_port_r) && $stable(rx_ptr_r))
    else $error("write disturbed receive port");

  c_soft_reset: cover property (soft_rst ##1 !soft_rst);
  c_stream_rx: cover property (fifo_pop ##[1:60] rd_rx_port);
  c_stream_tx: cover property (tx_strm_f_r ##[1:60] wr_tx_port);
  c_fifo_full: cover property (!rx_strm_ready);
endmodule : modem_packet_ram_access_regs

// ===== design/modem_regs_pkg.sv
// Shared constants, register map and carrier types of the modem register front end
package modem_regs_pkg;
  // Widths
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int LEN_W = 7;
  localparam int IDX_W = 6;
  localparam int RAM_DEPTH = 64;
  localparam int FIFO_DEPTH = 32;
  localparam int SYNC_W = 11;
  // Register offsets
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h00;
  localparam logic [5:0] ADDR_RX_PORT = 6'h01;
  localparam logic [5:0] ADDR_TX_PORT = 6'h02;
  localparam logic [5:0] ADDR_TX_CTL = 6'h03;
  localparam logic [5:0] ADDR_FLAGS = 6'h24;
  localparam logic [5:0] ADDR_RESET_CAUSE = 6'h25;
  localparam logic [5:0] ADDR_TIME_HI = 6'h26;
  localparam logic [5:0] ADDR_TIME_LO = 6'h27;
  localparam logic [5:0] ADDR_PIN_IN = 6'h28;
  localparam logic [5:0] ADDR_PART_ID = 6'h2C;
  localparam logic [5:0] ADDR_RX_QUAL = 6'h2D;
  localparam logic [5:0] ADDR_STAMP_HI = 6'h2E;
  localparam logic [5:0] ADDR_STAMP_LO = 6'h2F;
  localparam logic [5:0] ADDR_BER_EN = 6'h30;
  // Field positions
  localparam int TX_SEL_BIT = 15;
  localparam int BER_EN_BIT = 15;
  localparam int FLAG_STREAM_BIT = 11;
  localparam int FLAG_RX_RCVD_BIT = 7;
  localparam int FLAG_TX_SENT_BIT = 6;
  localparam int SYNC_CE = 0;
  localparam int SYNC_SRST = 1;
  localparam int SYNC_WR = 2;
  localparam int SYNC_RD = 3;
  localparam int SYNC_PIN_LO = 4;
  // Frame bit counts on the serial link
  localparam logic [3:0] HDR_ADDR_DONE = 4'h7;
  localparam logic [3:0] WORD_DONE = 4'hF;
  localparam int HDR_RW_BIT = 7;
  // Values after reset
  localparam logic [6:0] TX_LEN_RST = 7'h00;
  localparam logic TX_SEL_RST = 1'b0;
  localparam logic BER_EN_RST = 1'b0;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h001;
  localparam logic [3:0] PART_ID_DEFAULT = 4'h5; // Arbitrary value
  // Serial access seen by the core
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] data;
  } spi_access_t;
  // Received packet word from the radio
  typedef struct packed {
    logic [5:0] idx;
    logic [15:0] data;
  } rx_word_t;
endpackage : modem_regs_pkg

// ===== dv/modem_packet_ram_access_regs_tb_top.sv
// Self-checking bench for the modem serial register front end
`timescale 1ns/1ps
module modem_packet_ram_access_regs_tb_top;
  import modem_regs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic spi_clk, ce_n, mosi, miso, miso_oe, irq_n, srst_act, rd_stb;
  logic [15:0] irq_mask, rx_strm_data, tx_rd_data, tx_strm_word, rd_word;
  logic rx_stream_en, tx_stream_en, rx_pkt_wr, rx_pkt_done, rx_strm_valid;
  logic rx_strm_ready, tx_sel, tx_need, tx_sent, tx_strm_valid, ber_en;
  logic [6:0] rx_pkt_len, tx_len, len;
  logic [5:0] tx_rd_idx;
  rx_word_t rx_pkt_in;
  logic [31:0] seed = 32'h8725;
  logic [15:0] w [8];
  logic [15:0] t1 [8];
  logic [15:0] t2 [8];
  logic [15:0] r [8];
  logic [15:0] sq [40];
  logic [15:0] exp_q [$];
  logic [15:0] tq [$];
  int fail_count = 0;
  int n_tests = 0;
  int cyc_n = 0;
  int k;

  // Core clock, 5 ns period
  always #2.5 core_clk = ~core_clk;

  modem_packet_ram_access_regs dut_u (
    .core_clk(core_clk), .rst(rst), .spi_clk(spi_clk), .ce_n(ce_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .irq_n(irq_n),
    .soft_reset_active(srst_act), .irq_mask(irq_mask),
    .rx_stream_en(rx_stream_en), .tx_stream_en(tx_stream_en),
    .rx_pkt_wr(rx_pkt_wr), .rx_pkt_in(rx_pkt_in),
    .rx_pkt_done(rx_pkt_done), .rx_pkt_len(rx_pkt_len),
    .cca_final(8'hA5), .rx_strm_valid(rx_strm_valid),
    .rx_strm_data(rx_strm_data), .rx_strm_ready(rx_strm_ready),
    .tx_rd_idx(tx_rd_idx), .tx_rd_data(tx_rd_data), .tx_len(tx_len),
    .tx_sel(tx_sel), .tx_need(tx_need), .tx_sent(tx_sent),
    .tx_strm_word(tx_strm_word), .tx_strm_valid(tx_strm_valid),
    .event_time(24'h123456), .frame_stamp(24'h654321),
    .gpio_in(7'h2A), .ber_en(ber_en)
  );

  spi_host_model host_u (
    .spi_clk(spi_clk), .ce_n(ce_n), .mosi(mosi), .miso(miso),
    .rd_stb(rd_stb), .rd_word(rd_word)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic chk_word(input logic [15:0] got, input logic [15:0] ex);
    n_tests++;
    if (got !== ex) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
      fail_count++;
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic ex);
    n_tests++;
    if (got !== ex) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, ex);
      fail_count++;
    end
  endtask : chk_bit

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  // Burst read of n words, each noted for the monitor first
  task automatic rdn(input logic [5:0] a, input logic [15:0] t [8],
    input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(t[i]);
    host_u.xfer(1'b1, a, n, w, 0);
    @(negedge core_clk);
  endtask : rdn

  task automatic rd1(input logic [5:0] a, input logic [15:0] v);
    exp_q.push_back(v);
    host_u.xfer(1'b1, a, 1, w, 0);
    @(negedge core_clk);
  endtask : rd1

  task automatic wr(input logic [5:0] a, input int n);
    host_u.xfer(1'b0, a, n, w, 0);
    @(negedge core_clk);
  endtask : wr

  // Radio read port of the selected transmit RAM
  task automatic ram_chk(input logic [15:0] t [8]);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      tx_rd_idx = 6'(i);
      @(negedge core_clk);
      chk_word(tx_rd_data, t[i]);
    end
  endtask : ram_chk

  // Read monitor: oldest note against each word the host collects
  always @(posedge rd_stb) begin
    chk_bit(miso_oe, 1'b1);
    if (exp_q.size() == 0) chk_word(rd_word, 16'hXXXX);
    else chk_word(rd_word, exp_q.pop_front());
  end

  // Stream transmit monitor
  always @(negedge core_clk) begin
    if (tx_strm_valid === 1'b1) chk_word(tx_strm_word, tq.pop_front());
  end

  // Hang guard
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    {irq_mask, rx_stream_en, tx_stream_en, rx_pkt_wr, rx_pkt_in,
      rx_pkt_done, rx_pkt_len, rx_strm_valid, rx_strm_data, tx_rd_idx,
      tx_need, tx_sent} = '0;
    for (int i = 0; i < 8; i++) begin
      t1[i] = 16'(xs());
      t2[i] = 16'(xs());
      r[i] = 16'(xs());
      w[i] = 16'h0000;
    end
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    cyc(4);
    chk_bit(irq_n, 1'b1);
    chk_bit(miso_oe, 1'b0);
    chk_bit(srst_act, 1'b0);
    rd1(ADDR_RESET_CAUSE, 16'h0080);
    rd1(ADDR_RESET_CAUSE, 16'h0000);
    rd1(ADDR_SOFT_RESET, 16'h0000);
    rd1(6'h34, 16'h0000);
    rd1(ADDR_TIME_HI, 16'h0012);
    rd1(ADDR_TIME_LO, 16'h3456);
    rd1(ADDR_PIN_IN, 16'h2A00);
    rd1(ADDR_PART_ID, {4'h0, PART_ID_DEFAULT, 8'h00});
    rd1(ADDR_STAMP_HI, 16'h0065);
    rd1(ADDR_STAMP_LO, 16'h4321);
    // Select and length, then both transmit RAMs by burst
    w[0] = 16'h8000;
    wr(ADDR_BER_EN, 1);
    w[0] = 16'h8005;
    wr(ADDR_TX_CTL, 1);
    chk_bit(tx_sel, 1'b1);
    chk_word(16'(tx_len), 16'h0005);
    chk_bit(ber_en, 1'b1);
    rd1(ADDR_TX_CTL, 16'h8005);
    rd1(ADDR_BER_EN, 16'h8000);
    w = t2;
    wr(ADDR_TX_PORT, 4);
    w[0] = 16'h0007;
    wr(ADDR_TX_CTL, 1);
    w = t1;
    wr(ADDR_TX_PORT, 4);
    chk_bit(tx_sel, 1'b0);
    ram_chk(t1);
    rdn(ADDR_TX_PORT, t1, 4);
    w[0] = 16'h8007;
    wr(ADDR_TX_CTL, 1);
    ram_chk(t2);
    rdn(ADDR_TX_PORT, t2, 4);
    // Received packet into receive RAM
    irq_mask = 16'h0080;
    len = 7'(xs());
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      rx_pkt_wr = 1'b1;
      rx_pkt_in = {6'(i), r[i]};
    end
    @(negedge core_clk);
    rx_pkt_wr = 1'b0;
    rx_pkt_done = 1'b1;
    rx_pkt_len = len;
    @(negedge core_clk);
    rx_pkt_done = 1'b0;
    cyc(3);
    chk_bit(irq_n, 1'b0);
    rd1(ADDR_RX_QUAL, {8'hA5, 1'b0, len});
    rdn(ADDR_RX_PORT, r, 4);
    w = t2;
    wr(ADDR_RX_PORT, 4);
    rdn(ADDR_RX_PORT, r, 4);
    rd1(ADDR_FLAGS, 16'h0080);
    cyc(3);
    chk_bit(irq_n, 1'b1);
    // Soft reset held while chip enable stays low
    w[0] = 16'(xs());
    fork
      host_u.xfer(1'b0, ADDR_SOFT_RESET, 1, w, 300);
      begin
        #600;
        chk_bit(srst_act, 1'b1);
      end
    join
    cyc(2);
    chk_bit(srst_act, 1'b0);
    chk_bit(tx_sel, 1'b0);
    chk_word(16'(tx_len), 16'h0000);
    chk_bit(ber_en, 1'b0);
    rd1(ADDR_RESET_CAUSE, 16'h0080);
    rd1(ADDR_RX_QUAL, 16'hA500);
    rdn(ADDR_TX_PORT, t1, 4);
    rdn(ADDR_RX_PORT, r, 4);
    rd1(ADDR_BER_EN, 16'h0000);
    // Stream receive: fill until refused, then drain word by word
    rx_stream_en = 1'b1;
    irq_mask = 16'h0800;
    for (k = 0; k < 40; k++) begin
      @(negedge core_clk);
      rx_strm_valid = 1'b1;
      rx_strm_data = 16'(xs());
      #1;
      if (rx_strm_ready !== 1'b1) break;
      sq[k] = rx_strm_data;
    end
    @(negedge core_clk);
    rx_strm_valid = 1'b0;
    chk_word(16'(k), 16'(FIFO_DEPTH + 1));
    cyc(3);
    chk_bit(irq_n, 1'b0);
    for (int i = 0; i < k; i++) rd1(ADDR_RX_PORT, sq[i]);
    cyc(4);
    chk_bit(irq_n, 1'b1);
    rx_stream_en = 1'b0;
    // Stream transmit: request, then one write per word
    tx_stream_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(negedge core_clk);
      tx_need = 1'b1;
      @(negedge core_clk);
      tx_need = 1'b0;
      cyc(3);
      chk_bit(irq_n, 1'b0);
      w[0] = 16'(xs());
      tq.push_back(w[0]);
      wr(ADDR_TX_PORT, 1);
      chk_bit(irq_n, 1'b1);
    end
    tx_stream_en = 1'b0;
    // Packet sent event through the mask
    irq_mask = 16'h0040;
    @(negedge core_clk);
    tx_sent = 1'b1;
    @(negedge core_clk);
    tx_sent = 1'b0;
    cyc(3);
    chk_bit(irq_n, 1'b0);
    rd1(ADDR_FLAGS, 16'h0040);
    cyc(3);
    chk_word(16'(exp_q.size() + tq.size()), 16'h0000);
    tally_and_finish();
  end
endmodule : modem_packet_ram_access_regs_tb_top

// ===== dv/spi_host_model.sv
// Host-side serial master model that frames register accesses
`timescale 1ns/1ps
module spi_host_model (
  output logic spi_clk,
  output logic ce_n,
  output logic mosi,
  input wire logic miso,
  output logic rd_stb,
  output logic [15:0] rd_word
);
  // Link idle: clock parked low, chip enable high
  initial begin
    spi_clk = 1'b0;
    ce_n = 1'b1;
    mosi = 1'b0;
    rd_stb = 1'b0;
    rd_word = 16'h0000;
  end

  // One frame: header, pad, n words; a read stops before loading word n
  task automatic xfer(input logic rw, input logic [5:0] a, input int n,
    input logic [15:0] wd [8], input int hold);
    logic [7:0] hdr;
    logic [15:0] sh;
    int e;
    hdr = {rw, 1'b0, a};
    sh = 16'h0000;
    e = 16 + 16 * n - (rw ? 1 : 0);
    ce_n = 1'b0;
    #11; // Keeps link edges off the core clock edges
    for (int i = 0; i < e; i++) begin
      if (i < 8) mosi = hdr[7 - i];
      else if (i < 16) mosi = 1'b0;
      else mosi = wd[(i - 16) / 16][15 - (i % 16)];
      #7.5 spi_clk = 1'b1;
      #7.5 spi_clk = 1'b0;
      sh = {sh[14:0], miso};
      if (rw && i > 15 && i % 16 == 14) begin
        rd_word = sh;
        rd_stb = 1'b1;
        #1 rd_stb = 1'b0;
      end
    end
    // Released data line shows the inverse, clock stands still
    mosi = ~mosi;
    #(7 + hold) ce_n = 1'b1;
    #30;
  endtask : xfer
endmodule : spi_host_model
